// File: dv/ors_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ors_chk
   import ors_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Core port
   input  wire logic [23:0] CORE_ADDR,
   input  wire logic        CORE_RD,
   input  wire logic        CORE_WORD,
   input  wire logic [15:0] CORE_DATA,
   input  wire logic        CORE_ACK,
   input  wire logic        CORE_ERR,
   // Forward port
   input  wire logic [23:0] EXT_ADDR,
   input  wire logic        EXT_REQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_answer_once: assert property (CORE_RD |=> $onehot({CORE_ACK, CORE_ERR, EXT_REQ}))
      else $error("read not answered once");
   a_no_stray: assert property (!CORE_RD |=> !(CORE_ACK || CORE_ERR || EXT_REQ))
      else $error("answer without read");
   a_odd_lane: assert property (CORE_RD && !CORE_WORD && CORE_ADDR[0] |=>
      CORE_DATA[15:8] == 8'h00) else $error("odd byte on upper lane");
   a_even_lane: assert property (CORE_RD && !CORE_WORD && !CORE_ADDR[0] |=>
      CORE_DATA[7:0] == 8'h00) else $error("even byte on lower lane");
   a_fwd_addr: assert property (CORE_RD ##1 EXT_REQ |-> EXT_ADDR == $past(CORE_ADDR))
      else $error("forward address wrong");
   a_low_never_rsv: assert property (CORE_RD && CORE_ADDR <= ORS_LOW_ROM_END |=> !CORE_ERR)
      else $error("low range refused");
   c_ack: cover property (CORE_ACK);
   c_err: cover property (CORE_ERR);
   c_ext: cover property (EXT_REQ);
endmodule
bind ors_access_select ors_chk i_ors_chk (.CLK(CLK), .RST_N(RST_N), .CORE_ADDR(CORE_ADDR),
   .CORE_RD(CORE_RD), .CORE_WORD(CORE_WORD), .CORE_DATA(CORE_DATA), .CORE_ACK(CORE_ACK),
   .CORE_ERR(CORE_ERR), .EXT_ADDR(EXT_ADDR), .EXT_REQ(EXT_REQ));
`default_nettype wire

// File: dv/ors_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module ors_core_model (
   // Clock
   input  wire logic        CLK,
   // Read request
   output logic      [23:0] CORE_ADDR,
   output logic             CORE_RD,
   output logic             CORE_WORD
);
   initial begin
      CORE_ADDR = 24'h000000;
      CORE_RD = 1'b0;
      CORE_WORD = 1'b0;
   end
   task automatic rd(input logic [23:0] a, input logic w);
      @(posedge CLK);
      CORE_ADDR <= w ? {a[23:1], 1'b0} : a;
      CORE_WORD <= w;
      CORE_RD   <= 1'b1;
      @(posedge CLK);
      CORE_RD   <= 1'b0;
      // Address is stale once the strobe drops
      CORE_ADDR <= ~CORE_ADDR;
   endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
   import ors_pkg::*;
;
   logic        clk, rst_n, rwr, rrd, ld_en, rd, word, ack, err, ext_req, ext_word;
   logic [2:0]  mode;
   logic [3:0]  raddr;
   logic [7:0]  wdat, rdat;
   logic [15:0] data, ld_data;
   logic [16:0] ld_addr;
   logic [23:0] addr, ext_addr;
   int          n_mismatch, check_count, cyc;

   ors_core_model i_ors_core_model (.CLK(clk), .CORE_ADDR(addr), .CORE_RD(rd), .CORE_WORD(word));
   ors_access_select i_ors_access_select (.CLK(clk), .RST_N(rst_n), .OPERATING_MODE_PINS(mode),
      .CORE_ADDR(addr), .CORE_RD(rd), .CORE_WORD(word), .CORE_DATA(data), .CORE_ACK(ack),
      .CORE_ERR(err), .EXT_ADDR(ext_addr), .EXT_REQ(ext_req), .EXT_WORD(ext_word),
      .REG_ADDR(raddr), .REG_WDATA(wdat), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat),
      .LD_ADDR(ld_addr), .LD_DATA(ld_data), .LD_EN(ld_en));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end
   task chk(input logic [23:0] g, input logic [23:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task ld(input logic [16:0] a, input logic [15:0] d);
      @(posedge clk);
      ld_en <= 1'b1;
      ld_addr <= a;
      ld_data <= d;
      @(posedge clk);
      ld_en <= 1'b0;
   endtask
   task wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      raddr <= a;
      wdat <= d;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      raddr <= a;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
      #1 chk(rdat, e);
   endtask
   // Answer kind is {ack, err, ext_req}
   task core(input logic [23:0] a, input logic w, input logic [2:0] k, input logic [15:0] e);
      i_ors_core_model.rd(a, w);
      #1 chk({ack, err, ext_req}, k);
      chk(data, e);
   endtask
   // Mode pins pass a two-flop synchroniser
   task setm(input logic [2:0] m);
      @(posedge clk);
      mode <= m;
      repeat (3) @(posedge clk);
   endtask
   task t_reset;
      rreg(ORS_ADDR_BCL, 8'h3C);
      rreg(4'hF, 8'h00);
      $display("t_reset done");
   endtask
   task t_lanes;
      core(24'h000000, 1'b0, 3'h4, 16'hA100);
      core(24'h000001, 1'b0, 3'h4, 16'h00B2);
      core(24'h000000, 1'b1, 3'h4, 16'hA1B2);
      $display("t_lanes done");
   endtask
   task t_range;
      core(24'h010000, 1'b1, 3'h2, 16'h0000);
      rreg(ORS_ADDR_STATUS, 8'h05);
      wreg(ORS_ADDR_STATUS, 8'h04);
      wreg(ORS_ADDR_BCL, 8'h1C);
      rreg(ORS_ADDR_BCL, 8'h1C);
      rreg(ORS_ADDR_STATUS, 8'h03);
      core(24'h010000, 1'b1, 3'h4, 16'hC3D4);
      core(24'h010001, 1'b0, 3'h4, 16'h00D4);
      $display("t_range done");
   endtask
   task t_ext;
      wreg(ORS_ADDR_BCL, 8'h3C);
      setm(ORS_MODE_EXP_ROM);
      core(24'h010002, 1'b1, 3'h1, 16'h0000);
      chk(ext_addr, 24'h010002);
      chk(ext_word, 24'h000001);
      core(24'h000000, 1'b1, 3'h4, 16'hA1B2);
      setm(3'h0);
      core(24'h000000, 1'b1, 3'h1, 16'h0000);
      $display("t_ext done");
   endtask
   // Mid-run reset must restore the register over a written value
   task t_rst2;
      wreg(ORS_ADDR_BCL, 8'h1C);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(ORS_ADDR_BCL, 8'h3C);
      rreg(ORS_ADDR_STATUS, 8'h00);
      $display("t_rst2 done");
   endtask
   initial begin
      {rst_n, rwr, rrd, ld_en} = 4'h0;
      mode = ORS_MODE_SINGLE_A;
      raddr = 4'h0;
      wdat = 8'h00;
      ld_addr = 17'h00000;
      ld_data = 16'h0000;
      {n_mismatch, check_count, cyc} = 0;
      ld(17'h00000, 16'hA1B2);
      ld(17'h08000, 16'hC3D4);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_lanes;
      t_range;
      t_ext;
      t_rst2;
      results();
   end
endmodule
`default_nettype wire

// File: hdl/ors_access_select.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module ors_access_select
   import ors_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Mode pins
   input  wire logic [2:0]  OPERATING_MODE_PINS,
   // Core read port
   input  wire logic [23:0] CORE_ADDR,
   input  wire logic        CORE_RD,
   input  wire logic        CORE_WORD,
   output logic      [15:0] CORE_DATA,
   output logic             CORE_ACK,
   output logic             CORE_ERR,
   // External bus controller forward
   output logic      [23:0] EXT_ADDR,
   output logic             EXT_REQ,
   output logic             EXT_WORD,
   // Register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   // Program image load
   input  wire logic [16:0] LD_ADDR,
   input  wire logic [15:0] LD_DATA,
   input  wire logic        LD_EN
);

   // Mode pins are off-chip, two flops before use
   logic [2:0]  mode_meta_ff;
   logic [2:0]  mode_ff;
   logic [7:0]  bus_control_low_ff;
   logic        rsv_hit_ff;
   logic        misalign_ff;
   logic        rom_pend_ff;
   logic        odd_ff;
   logic        word_ff;
   logic [15:0] rom_word;
   logic [15:0] nxt_core_data;
   ors_dest_e   dest;
   logic        external_range_enable;
   logic        single_chip;
   logic        rom_enabled;
   logic        rom_hit;
   logic [7:0]  status_word;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mode_meta_ff <= 3'h0;
         mode_ff      <= 3'h0;
      end else begin
         mode_meta_ff <= OPERATING_MODE_PINS;
         mode_ff      <= mode_meta_ff;
      end
   end

   assign external_range_enable = bus_control_low_ff[ORS_BCL_EXT_BIT];
   // Only expanded-with-ROM and single-chip modes enable the ROM
   assign rom_enabled = (mode_ff == ORS_MODE_EXP_ROM) || (mode_ff == ORS_MODE_SINGLE_A);
   assign single_chip = (mode_ff == ORS_MODE_SINGLE_A);

   function automatic ors_dest_e decode(input logic [23:0] a, input logic rom_on,
                                        input logic ext_en, input logic sc);
      if (!rom_on) begin
         decode = sc ? ORS_DEST_RSV : ORS_DEST_EXT;
      end else if (a <= ORS_LOW_ROM_END) begin
         decode = ORS_DEST_ROM;
      end else if (a >= ORS_MID_START && a <= ORS_MID_END) begin
         if (!ext_en) begin
            decode = ORS_DEST_ROM;
         end else if (sc) begin
            decode = ORS_DEST_RSV;
         end else begin
            decode = ORS_DEST_EXT;
         end
      end else begin
         decode = sc ? ORS_DEST_RSV : ORS_DEST_EXT;
      end
   endfunction

   assign dest    = decode(CORE_ADDR, rom_enabled, external_range_enable, single_chip);
   assign rom_hit = CORE_RD && (dest == ORS_DEST_ROM);

   // Bus control low register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bus_control_low_ff <= ORS_BCL_RESET;
      end else if (REG_WR && REG_ADDR == ORS_ADDR_BCL) begin
         bus_control_low_ff <= REG_WDATA;
      end
   end

   function automatic logic dest_mid_internal(input logic rom_on, input logic ext_en);
      dest_mid_internal = rom_on && !ext_en;
   endfunction

   // Status bits sit at their named positions; the rest read zero
   always_comb begin
      status_word                  = 8'h00;
      status_word[ORS_ST_ROM_EN]   = rom_enabled;
      status_word[ORS_ST_MID_INT]  = dest_mid_internal(rom_enabled, external_range_enable);
      status_word[ORS_ST_RSV_HIT]  = rsv_hit_ff;
      status_word[ORS_ST_MISALIGN] = misalign_ff;
   end

   // Register read, data in following cycle; unmapped reads zero
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         if (REG_ADDR == ORS_ADDR_BCL) begin
            REG_RDATA <= bus_control_low_ff;
         end else if (REG_ADDR == ORS_ADDR_STATUS) begin
            REG_RDATA <= status_word;
         end else begin
            REG_RDATA <= 8'h00;
         end
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // Sticky diagnostics; a new hit wins over the clearing write
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rsv_hit_ff  <= 1'b0;
         misalign_ff <= 1'b0;
      end else begin
         if (CORE_RD && dest == ORS_DEST_RSV) begin
            rsv_hit_ff <= 1'b1;
         end else if (REG_WR && REG_ADDR == ORS_ADDR_STATUS && REG_WDATA[ORS_ST_RSV_HIT]) begin
            rsv_hit_ff <= 1'b0;
         end
         // Odd word address is a core fault; flagged, not corrected
         if (rom_hit && CORE_WORD && CORE_ADDR[0]) begin
            misalign_ff <= 1'b1;
         end else if (REG_WR && REG_ADDR == ORS_ADDR_STATUS && REG_WDATA[ORS_ST_MISALIGN]) begin
            misalign_ff <= 1'b0;
         end
      end
   end

   ors_rom_mem u_mem (
      .CLK     (CLK),
      .rd_addr (CORE_ADDR[17:1]),
      .rd_en   (rom_hit),
      .rd_data (rom_word),
      .ld_addr (LD_ADDR),
      .ld_data (LD_DATA),
      .ld_en   (LD_EN)
   );

   // Read tracking: answer in the state after the request
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rom_pend_ff <= 1'b0;
         odd_ff      <= 1'b0;
         word_ff     <= 1'b0;
      end else begin
         rom_pend_ff <= rom_hit;
         odd_ff      <= CORE_ADDR[0];
         word_ff     <= CORE_WORD;
      end
   end

   // Byte lane steering
   always_comb begin
      if (word_ff) begin
         nxt_core_data = rom_word;
      end else if (odd_ff) begin
         nxt_core_data = {8'h00, rom_word[7:0]};
      end else begin
         nxt_core_data = {rom_word[15:8], 8'h00};
      end
   end

   assign CORE_DATA = rom_pend_ff ? nxt_core_data : 16'h0000;
   assign CORE_ACK  = rom_pend_ff;

   // Reserved hit errors instead of returning junk
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         CORE_ERR <= 1'b0;
      end else begin
         CORE_ERR <= CORE_RD && (dest == ORS_DEST_RSV);
      end
   end

   // External forwarding
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EXT_REQ  <= 1'b0;
         EXT_ADDR <= 24'h000000;
         EXT_WORD <= 1'b0;
      end else begin
         EXT_REQ <= CORE_RD && (dest == ORS_DEST_EXT);
         if (CORE_RD && dest == ORS_DEST_EXT) begin
            EXT_ADDR <= CORE_ADDR;
            EXT_WORD <= CORE_WORD;
         end
      end
   end

endmodule
`default_nettype wire

// File: hdl/ors_pkg.sv
package ors_pkg;

   // Bus control low register, bit layout and reset value
   localparam logic [7:0]  ORS_BCL_RESET     = 8'h3C;
   localparam int          ORS_BCL_EXT_BIT   = 5;
   localparam logic [3:0]  ORS_ADDR_BCL      = 4'h0;
   localparam logic [3:0]  ORS_ADDR_STATUS   = 4'h1;

   // Address map
   localparam logic [23:0] ORS_LOW_ROM_END   = 24'h00FFFF;
   localparam logic [23:0] ORS_MID_START     = 24'h010000;
   localparam logic [23:0] ORS_MID_END       = 24'h03FFFF;

   // Memory geometry: 16-bit words covering 0 to MID_END
   localparam int          ORS_WORD_AW       = 17;

   // Operating mode pin codes
   localparam logic [2:0]  ORS_MODE_SINGLE_A = 3'h7;
   localparam logic [2:0]  ORS_MODE_EXP_ROM  = 3'h6;

   // Status register field positions
   localparam int          ORS_ST_ROM_EN     = 0;
   localparam int          ORS_ST_MID_INT    = 1;
   localparam int          ORS_ST_RSV_HIT    = 2;
   localparam int          ORS_ST_MISALIGN   = 3;

   typedef enum logic [2:0] {
      ORS_DEST_ROM = 3'b001,
      ORS_DEST_EXT = 3'b010,
      ORS_DEST_RSV = 3'b100
   } ors_dest_e;

endpackage

// File: hdl/ors_rom_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ors_rom_mem
   import ors_pkg::*;
(
   // Clock
   input  wire logic                   CLK,
   // Read port
   input  wire logic [ORS_WORD_AW-1:0] rd_addr,
   input  wire logic                   rd_en,
   output logic      [15:0]            rd_data,
   // Load port for program image
   input  wire logic [ORS_WORD_AW-1:0] ld_addr,
   input  wire logic [15:0]            ld_data,
   input  wire logic                   ld_en
);

   logic [15:0] mem [0:(1<<ORS_WORD_AW)-1];

   // Registered read, one word per state
   always_ff @(posedge CLK) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

   always_ff @(posedge CLK) begin
      if (ld_en) begin
         mem[ld_addr] <= ld_data;
      end
   end

endmodule
`default_nettype wire
